// ==== common/ipx_pkg.sv ====
// constants shared by the extended serial port control block
package ipx_pkg;
  // ==========================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEQ_REQ = 8'h04;
  localparam logic [7:0] ADDR_BUF = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam int ADDR_W = 8;
  // ==========================================================================
  // extended control field positions
  localparam int BIT_ACK_WIN = 7;
  localparam int BIT_STOP_IE = 6;
  localparam int BIT_START_IE = 5;
  localparam int BIT_BUF_OVWR = 4;
  localparam int BIT_HOLD_SEL = 3;
  localparam int BIT_SLV_COLL = 2;
  localparam int BIT_ADDR_HOLD = 1;
  localparam int BIT_DATA_HOLD = 0;
  localparam int CTRL_W = 7;
  localparam logic [6:0] EXT_CTRL_RESET = 7'h00;
  // ==========================================================================
  // sequence request field positions
  localparam int REQ_ACK = 4;
  localparam int REQ_RX = 3;
  localparam int REQ_STOP = 2;
  localparam int REQ_RESTART = 1;
  localparam int REQ_START = 0;
  localparam int REQ_W = 5;
  localparam logic [4:0] REQ_RESET = 5'h00;
  // ==========================================================================
  // data, mode and status layout
  localparam int DATA_W = 8;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] MODE_SLV7_SS = 4'hE;
  localparam logic [3:0] MODE_SLV10_SS = 4'hF;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_CNT_LO = 4;
  // ==========================================================================
  // bit counting on the serial clock
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] ACK_RISES = 4'h8;
  // ==========================================================================
  // sda hold timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_LONG_NS = 300;
  localparam int HOLD_SHORT_NS = 100;
  localparam int HOLD_W = 6;
  localparam logic [5:0] HOLD_LONG_CYC =
    6'((HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] HOLD_SHORT_CYC =
    6'((HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] HOLD_ZERO = 6'h00;
  localparam logic [5:0] HOLD_ONE = 6'h01;
  // ==========================================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== design/ipx_sda_hold.sv ====
// sda drive hold timer after the falling serial clock edge
`timescale 1ns/1ns
module ipx_sda_hold (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control
  input wire logic scl_fall,
  input wire logic hold_sel,
  input wire logic drive_req,
  // held drive level, 1 pulls sda low
  output logic sda_drive_r
);
  // ==========================================================================
  // hold counter
  logic [ipx_pkg::HOLD_W-1:0] hold_cnt_r;
  logic [ipx_pkg::HOLD_W-1:0] since_fall_r;

  // load on each falling edge, count down to zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_cnt_r <= ipx_pkg::HOLD_ZERO;
    else if (scl_fall)
      hold_cnt_r <= hold_sel ? ipx_pkg::HOLD_LONG_CYC : ipx_pkg::HOLD_SHORT_CYC;
    else if (hold_cnt_r != ipx_pkg::HOLD_ZERO)
      hold_cnt_r <= hold_cnt_r - ipx_pkg::HOLD_ONE;
  end

  // drive level follows the request only once the hold has run out
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      sda_drive_r <= 1'b0;
    else if (!scl_fall && hold_cnt_r == ipx_pkg::HOLD_ZERO)
      sda_drive_r <= drive_req;
  end

  // ==========================================================================
  // checks
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      since_fall_r <= ipx_pkg::HOLD_LONG_CYC;
    else if (scl_fall)
      since_fall_r <= ipx_pkg::HOLD_ZERO;
    else if (since_fall_r != ipx_pkg::HOLD_LONG_CYC)
      since_fall_r <= since_fall_r + ipx_pkg::HOLD_ONE;
  end

  logic hold_sel_r;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_sel_r <= 1'b0;
    else if (scl_fall)
      hold_sel_r <= hold_sel;
  end

  a_hold_min_time: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $changed(sda_drive_r) |->
      ($past(since_fall_r) >= (hold_sel_r ? ipx_pkg::HOLD_LONG_CYC : ipx_pkg::HOLD_SHORT_CYC)))
    else $error("sda changed before hold time elapsed");
endmodule

// ==== design/ipx_top.sv ====
// extended control and status of the serial port with bus slave
`timescale 1ns/1ns
// How it works
// - request bits refused while engine busy
// - buffer writes ignored while engine busy
// - stop enable gates interrupt on stop
// - start enable gates interrupt on start/restart
// - hold select picks 300 or 100 ns
// - ack flag only with address/data hold
// - start/stop enables moot in detecting slave modes
module ipx_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_level,
  output logic sda_oe_n,
  // bus engine side
  input wire logic engine_idle,
  input wire logic [4:0] req_done,
  input wire logic engine_sda_drive,
  output logic [4:0] seq_request,
  output logic [7:0] serial_buffer,
  output logic buffer_load,
  output logic buffer_overwrite_enable,
  output logic slave_collision_detect_enable,
  // port event
  output logic port_irq
);
  // ==========================================================================
  // bus slave
  logic wr_pend_r;
  logic [ipx_pkg::ADDR_W-1:0] wr_addr_r;
  logic addr_ok;
  logic [ipx_pkg::CTRL_W-1:0] ext_ctrl_r;
  logic [ipx_pkg::REQ_W-1:0] req_r;
  logic [ipx_pkg::DATA_W-1:0] buf_r;
  logic [ipx_pkg::MODE_W-1:0] mode_r;
  logic ack_flag_r;
  logic [ipx_pkg::CNT_W-1:0] rise_cnt_r;
  logic [31:0] rd_nxt;

  assign addr_ok = hsel && hready && htrans == ipx_pkg::HTRANS_NONSEQ;

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (haddr[ipx_pkg::ADDR_W-1:0])
      ipx_pkg::ADDR_EXT_CTRL:
      begin
        rd_nxt[ipx_pkg::BIT_ACK_WIN] = ack_flag_r;
        rd_nxt[ipx_pkg::CTRL_W-1:0] = ext_ctrl_r;
      end
      ipx_pkg::ADDR_SEQ_REQ: rd_nxt[ipx_pkg::REQ_W-1:0] = req_r;
      ipx_pkg::ADDR_BUF: rd_nxt[ipx_pkg::DATA_W-1:0] = buf_r;
      ipx_pkg::ADDR_STATUS:
      begin
        rd_nxt[ipx_pkg::STAT_BUSY] = !engine_idle;
        rd_nxt[ipx_pkg::STAT_ACK] = ack_flag_r;
        rd_nxt[ipx_pkg::STAT_CNT_LO +: ipx_pkg::CNT_W] = rise_cnt_r;
      end
      ipx_pkg::ADDR_MODE: rd_nxt[ipx_pkg::MODE_W-1:0] = mode_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // address phase capture, zero wait states
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= ipx_pkg::ADDR_EXT_CTRL;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= ipx_pkg::HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= ipx_pkg::HRESP_OKAY;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_r <= haddr[ipx_pkg::ADDR_W-1:0];
      if (addr_ok && !hwrite)
        hrdata <= rd_nxt;
    end
  end

  // ==========================================================================
  // software registers
  logic wr_ctrl;
  logic wr_seq;
  logic wr_buf;
  assign wr_ctrl = wr_pend_r && wr_addr_r == ipx_pkg::ADDR_EXT_CTRL;
  assign wr_seq = wr_pend_r && wr_addr_r == ipx_pkg::ADDR_SEQ_REQ;
  assign wr_buf = wr_pend_r && wr_addr_r == ipx_pkg::ADDR_BUF;

  // control and mode registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_ctrl_r <= ipx_pkg::EXT_CTRL_RESET;
      mode_r <= ipx_pkg::MODE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ext_ctrl_r <= hwdata[ipx_pkg::CTRL_W-1:0];
      if (wr_pend_r && wr_addr_r == ipx_pkg::ADDR_MODE)
        mode_r <= hwdata[ipx_pkg::MODE_W-1:0];
    end
  end

  // request bits: set only when idle, set wins over engine clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      req_r <= ipx_pkg::REQ_RESET;
    else if (wr_seq && engine_idle)
      req_r <= (req_r & ~req_done) | hwdata[ipx_pkg::REQ_W-1:0];
    else
      req_r <= req_r & ~req_done;
  end

  // transmit buffer, one load pulse per accepted write
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      buf_r <= ipx_pkg::BUF_RESET;
      buffer_load <= 1'b0;
    end
    else
    begin
      buffer_load <= wr_buf && engine_idle;
      if (wr_buf && engine_idle)
        buf_r <= hwdata[ipx_pkg::DATA_W-1:0];
    end
  end

  assign seq_request = req_r;
  assign serial_buffer = buf_r;
  assign buffer_overwrite_enable = ext_ctrl_r[ipx_pkg::BIT_BUF_OVWR];
  assign slave_collision_detect_enable = ext_ctrl_r[ipx_pkg::BIT_SLV_COLL];

  // ==========================================================================
  // pin synchronisers and filtered levels
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r;
  logic sda_f_r;

  // three stages, a level counts once the last two agree
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[1:0], scl_pin};
      sda_s_r <= {sda_s_r[1:0], sda_pin};
      if (scl_s_r[1] == scl_s_r[2])
        scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2])
        sda_f_r <= sda_s_r[2];
    end
  end

  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_new = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
  assign sda_new = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
  assign scl_rise = scl_new && !scl_f_r;
  assign scl_fall = !scl_new && scl_f_r;
  assign start_det = scl_f_r && scl_new && sda_f_r && !sda_new;
  assign stop_det = scl_f_r && scl_new && !sda_f_r && sda_new;

  // ==========================================================================
  // acknowledge window tracking
  logic hold_en;
  assign hold_en = ext_ctrl_r[ipx_pkg::BIT_ADDR_HOLD] || ext_ctrl_r[ipx_pkg::BIT_DATA_HOLD];

  // rising edges per byte, reset by start and after the ninth
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rise_cnt_r <= ipx_pkg::CNT_ZERO;
    else if (start_det || stop_det)
      rise_cnt_r <= ipx_pkg::CNT_ZERO;
    else if (scl_rise && rise_cnt_r == ipx_pkg::ACK_RISES)
      rise_cnt_r <= ipx_pkg::CNT_ZERO;
    else if (scl_rise)
      rise_cnt_r <= rise_cnt_r + ipx_pkg::CNT_ONE;
  end

  // flag high from eighth fall to ninth rise
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_flag_r <= 1'b0;
    else if (!hold_en || start_det || stop_det)
      ack_flag_r <= 1'b0;
    else if (scl_fall && rise_cnt_r == ipx_pkg::ACK_RISES)
      ack_flag_r <= 1'b1;
    else if (scl_rise && rise_cnt_r == ipx_pkg::ACK_RISES)
      ack_flag_r <= 1'b0;
  end

  // ==========================================================================
  // start and stop event
  logic mode_ss;
  assign mode_ss = mode_r == ipx_pkg::MODE_SLV7_SS || mode_r == ipx_pkg::MODE_SLV10_SS;

  // detecting slave modes interrupt regardless of the enables
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      port_irq <= 1'b0;
    else
      port_irq <= (stop_det && (ext_ctrl_r[ipx_pkg::BIT_STOP_IE] || mode_ss))
        || (start_det && (ext_ctrl_r[ipx_pkg::BIT_START_IE] || mode_ss));
  end

  // ==========================================================================
  // sda drive with hold time
  logic sda_drive;
  ipx_sda_hold u_hold (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .scl_fall(scl_fall),
    .hold_sel(ext_ctrl_r[ipx_pkg::BIT_HOLD_SEL]),
    .drive_req(engine_sda_drive),
    .sda_drive_r(sda_drive)
  );

  // open drain: low level only, enable low while pulling
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_level <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_level <= 1'b0;
      sda_oe_n <= !sda_drive;
    end
  end

  // ==========================================================================
  // checks
  sequence s_seq_wr_busy;
    wr_seq && !engine_idle && (req_done == ipx_pkg::REQ_RESET);
  endsequence
  sequence s_buf_wr_busy;
    wr_buf && !engine_idle;
  endsequence
  sequence s_ack_open;
    hold_en && !start_det && !stop_det && scl_fall && rise_cnt_r == ipx_pkg::ACK_RISES;
  endsequence
  sequence s_ack_close;
    scl_rise && rise_cnt_r == ipx_pkg::ACK_RISES;
  endsequence

  a_req_busy_block: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_seq_wr_busy |=> $stable(seq_request))
    else $error("request bit changed while engine busy");

  a_buf_busy_ignore: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_buf_wr_busy |=> $stable(serial_buffer) && !buffer_load)
    else $error("buffer written while engine busy");

  a_ack_window_set: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_ack_open |=> ack_flag_r)
    else $error("ack flag not set at eighth falling edge");

  a_ack_window_clear: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_ack_close |=> !ack_flag_r && rise_cnt_r == ipx_pkg::CNT_ZERO)
    else $error("ack flag not cleared at ninth rising edge");

  a_ack_needs_hold: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !hold_en |=> !ack_flag_r)
    else $error("ack flag active without hold enable");

  a_stop_irq_on: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    stop_det && ext_ctrl_r[ipx_pkg::BIT_STOP_IE] |=> port_irq)
    else $error("stop did not raise interrupt");

  a_stop_irq_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    stop_det && !ext_ctrl_r[ipx_pkg::BIT_STOP_IE] && !mode_ss |=> !port_irq)
    else $error("stop raised interrupt while disabled");

  a_start_irq_gate: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    start_det && !mode_ss |=> port_irq == $past(ext_ctrl_r[ipx_pkg::BIT_START_IE]))
    else $error("start interrupt does not follow enable");

  a_mode_ss_irq: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (start_det || stop_det) && mode_ss |=> port_irq)
    else $error("detecting slave mode missed interrupt");
endmodule

// ==== testbench/ipx_i2c_master.sv ====
// behavioural serial bus master driving the clock and data pins
`timescale 1ns/1ns
module ipx_i2c_master (
  // clock
  input wire logic ref_clk,
  // open-drain drives, 1 releases the line
  output logic scl,
  output logic sda_rel
);
  // one third of one serial clock period (clock high time), in system cycles
  localparam int HALF = 50;
  // bus idle high, clock stands still outside frames
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait whole system cycles
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // data changes while the clock is low, except in start and stop
  task automatic put(input logic b);
    sda_rel <= b;
    pause(HALF);
  endtask
  task automatic hi();
    scl <= 1'b1;
    pause(HALF);
  endtask
  task automatic lo();
    scl <= 1'b0;
    pause(HALF);
  endtask
  // one clock with a data bit
  task automatic bit_out(input logic b);
    put(b);
    hi();
    lo();
  endtask
  // data falls while the clock is high
  task automatic start();
    put(1'b0);
    lo();
  endtask
  // data rises while the clock is high
  task automatic stop();
    put(1'b0);
    hi();
    put(1'b1);
  endtask
endmodule

// ==== testbench/tb_ipx_top.sv ====
// self-checking bench for the extended serial port control block
`timescale 1ns/1ns
module tb_ipx_top;
  // ==========================================================================
  // signals
  logic ref_clk, reset_n, hsel, hwrite, engine_idle, engine_sda_drive;
  logic [31:0] haddr, hwdata, hrdata, q, rnd;
  logic [1:0] htrans;
  logic [4:0] req_done, seq_request;
  logic [7:0] serial_buffer;
  logic hreadyout, hresp, sda_level, sda_oe_n, buffer_load, port_irq, boe, sbc, scl, sda_rel;
  wire sda = sda_rel & (sda_oe_n | sda_level);
  int err_count, n_compared, cyc, irq_n, load_n, n;
  // ==========================================================================
  // instances
  ipx_top u_dut (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .scl_pin(scl), .sda_pin(sda),
    .sda_level, .sda_oe_n, .engine_idle, .req_done, .engine_sda_drive, .seq_request,
    .serial_buffer, .buffer_load, .buffer_overwrite_enable(boe),
    .slave_collision_detect_enable(sbc), .port_irq);
  ipx_i2c_master u_mst (.ref_clk, .scl, .sda_rel);
  // clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int irq_exp(input logic en, input logic ss);
    return (en | ss) ? 1 : 0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one single transfer, read data left in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= ipx_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", hresp, ipx_pkg::HRESP_OKAY);
  endtask
  // pulse counters and hang limit
  always @(posedge ref_clk)
  begin
    cyc++;
    if (port_irq === 1'b1) irq_n++;
    if (buffer_load === 1'b1) load_n++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, req_done, engine_sda_drive} = '0;
    engine_idle = 1'b1;
    reset_n = 1'b0;
    rnd = 32'h00010563;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, unmapped place included
    for (int a = 0; a < 24; a += 4)
    begin
      bus(1'b0, 8'(a), 32'h0);
      chk("reset value", q, 32'h0);
    end
    rnd = step(rnd);
    bus(1'b1, 8'h14, rnd);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", q, 32'h0);
    // control bits, flag bit read-only
    bus(1'b1, ipx_pkg::ADDR_EXT_CTRL, rnd | 32'h80);
    bus(1'b0, ipx_pkg::ADDR_EXT_CTRL, 32'h0);
    chk("ctrl", q, {25'h0, rnd[6:0]});
    chk("outputs", {boe, sbc}, {rnd[ipx_pkg::BIT_BUF_OVWR], rnd[ipx_pkg::BIT_SLV_COLL]});
    // requests refused while busy, taken and cleared when idle
    engine_idle <= 1'b0;
    bus(1'b1, ipx_pkg::ADDR_SEQ_REQ, 32'h1F);
    bus(1'b0, ipx_pkg::ADDR_SEQ_REQ, 32'h0);
    chk("busy req", q, 32'h0);
    bus(1'b0, ipx_pkg::ADDR_STATUS, 32'h0);
    chk("busy status", q, 32'h1);
    engine_idle <= 1'b1;
    rnd = step(rnd);
    bus(1'b1, ipx_pkg::ADDR_SEQ_REQ, rnd | 32'h1);
    bus(1'b0, ipx_pkg::ADDR_SEQ_REQ, 32'h0);
    chk("idle req", q, {27'h0, rnd[4:1], 1'b1});
    chk("seq_request", seq_request, {rnd[4:1], 1'b1});
    req_done <= 5'h1F;
    @(posedge ref_clk);
    req_done <= 5'h00;
    bus(1'b0, ipx_pkg::ADDR_SEQ_REQ, 32'h0);
    chk("req done", q, 32'h0);
    // buffer writes ignored while busy
    rnd = step(rnd);
    bus(1'b1, ipx_pkg::ADDR_BUF, rnd);
    engine_idle <= 1'b0;
    bus(1'b1, ipx_pkg::ADDR_BUF, ~rnd);
    repeat (3) @(posedge ref_clk);
    chk("buffer", serial_buffer, rnd[7:0]);
    chk("loads", load_n, 32'h1);
    engine_idle <= 1'b1;
    // start and stop interrupts over enables and modes
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, ipx_pkg::ADDR_MODE,
        32'(i[2] ? (i[0] ? ipx_pkg::MODE_SLV10_SS : ipx_pkg::MODE_SLV7_SS) : 4'h0));
      bus(1'b1, ipx_pkg::ADDR_EXT_CTRL, 32'(i[1:0]) << ipx_pkg::BIT_START_IE);
      irq_n = 0;
      u_mst.start();
      n = irq_n;
      chk("start irq", n, irq_exp(i[0], i[2]));
      u_mst.stop();
      chk("stop irq", irq_n - n, irq_exp(i[1], i[2]));
    end
    bus(1'b1, ipx_pkg::ADDR_MODE, 32'h0);
    // acknowledge window flag: none, data hold, address hold
    for (int h = 0; h < 3; h++)
    begin
      bus(1'b1, ipx_pkg::ADDR_EXT_CTRL, 32'(h));
      u_mst.start();
      for (int k = 0; k < 8; k++)
      begin
        rnd = step(rnd);
        u_mst.bit_out(rnd[0]);
        bus(1'b0, ipx_pkg::ADDR_EXT_CTRL, 32'h0);
        chk("ack flag", q[7], k == 7 && h != 0);
      end
      u_mst.put(1'b1);
      u_mst.hi();
      bus(1'b0, ipx_pkg::ADDR_EXT_CTRL, 32'h0);
      chk("ack flag end", q[7], 32'h0);
      u_mst.lo();
      u_mst.stop();
    end
    // data hold after the falling clock for both selections
    for (int s = 0; s < 2; s++)
    begin
      bus(1'b1, ipx_pkg::ADDR_EXT_CTRL, 32'(s) << ipx_pkg::BIT_HOLD_SEL);
      u_mst.start();
      u_mst.put(1'b1);
      u_mst.hi();
      n = 0;
      fork
        u_mst.lo();
        begin
          // engine acts on the synchronised fall, hold counted from there
          repeat (4) @(posedge ref_clk);
          engine_sda_drive <= 1'b1;
          while (sda_oe_n !== 1'b0 && n < 48)
          begin
            @(posedge ref_clk);
            n++;
          end
        end
      join
      chk("hold", n >= (s ? ipx_pkg::HOLD_LONG_CYC : ipx_pkg::HOLD_SHORT_CYC) && n < 48,
        32'h1);
      chk("sda level", sda_level, 32'h0);
      engine_sda_drive <= 1'b0;
      u_mst.pause(10);
      u_mst.stop();
    end
    conclude();
  end
endmodule
